// ==== src/cpch_device.sv ====
// cpch_device: device end that interprets and executes parameter services
// Notes on behaviour
// - master loads index into bytes 2,3
// - master then writes read identifier
// - master toggles handshake last for read
// - read ignores data bytes and length
// - device toggles reply handshake when done
// - read accepted as 01/11/21/31 or 41/51/61/71
// - write: index then data bytes 4-7
// - master sets write identifier and length
// - write length is always four bytes
// - valid write is 32 or 72
// - master toggles only after full preparation
// - without toggle device ignores channel, reply unchanged
// - any handshake change starts a service
// - old handshake kept until execution ends
// - master waits for matching handshake
// - bad service code gives 5/5/0
// - bad write length gives 6/8/0
// - failure sets status, codes in 4-7
// - internal fault gives 6/2/0
`timescale 1ns/1ps
module cpch_device #(
  parameter int NPAR = 256,
  parameter int EXEC_CYC = 4
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // channel
  cpch_if.dev              ch,
  // internal parameter store fault
  input  wire logic        intFault,
  // service activity
  output logic             busy
);
  typedef enum logic [1:0] {IDLE, EXEC, DONE} cpch_st_e;
  typedef struct packed {
    cpch_st_e    st;
    logic        hsSeen;
    logic        hsOut;
    logic [7:0]  mgmt;
    logic [7:0]  rsv;
    logic [15:0] idx;
    logic [31:0] data;
    logic [31:0] res;
    logic [7:0]  cnt;
    logic        err;
    logic        busy;
  } cpch_dev_s;
  cpch_dev_s s_q, s_d;

  // ---------------------------------------------------------------
  // parameter store and decoded request fields
  // ---------------------------------------------------------------
  localparam int AW = $clog2(NPAR);
  logic [31:0]   mem [0:NPAR-1];
  logic          memWe;
  logic [7:0]    mgmtIn;
  logic [31:0]   memRd;
  logic          hsToggled;
  logic          codeBad;
  logic          isRead;
  logic          isWrite;
  logic          lenOk;

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // builds an error reply word: class, code, zero additional code
  function automatic logic [31:0] errWord(input logic [7:0] c, input logic [7:0] e);
    errWord = {c, e, 16'h0000};
  endfunction

  // service identifier field of a management byte
  function automatic logic [3:0] sidOf(input logic [7:0] m);
    sidOf = m[cpch_pkg::SID_LSB +: cpch_pkg::SID_W];
  endfunction

  // data length code field of a management byte
  function automatic logic [1:0] lenOf(input logic [7:0] m);
    lenOf = m[cpch_pkg::LEN_LSB +: cpch_pkg::LEN_W];
  endfunction

  // store word picked by the low bits of a parameter index
  function automatic logic [AW-1:0] addrOf(input logic [15:0] i);
    addrOf = i[AW-1:0];
  endfunction

  // ---------------------------------------------------------------
  // request decode: service fields from the captured copy, handshake from the live byte
  // ---------------------------------------------------------------
  // a live byte could change under a running service, so the service fields are decoded only from the capture
  assign mgmtIn = ch.reqByte[0];
  assign hsToggled = mgmtIn[cpch_pkg::HS_BIT] != s_q.hsSeen;
  assign codeBad = (s_q.rsv != 8'h00) || s_q.mgmt[7];
  assign isRead = sidOf(s_q.mgmt) == cpch_pkg::SID_READ;
  assign isWrite = sidOf(s_q.mgmt) == cpch_pkg::SID_WRITE;
  assign lenOk = lenOf(s_q.mgmt) == cpch_pkg::LEN_FOUR;
  assign memRd = mem[addrOf(s_q.idx)];

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    memWe = 1'b0;
    unique case (s_q.st)
      IDLE:
      begin
        if (hsToggled)
        begin
          s_d.hsSeen = mgmtIn[cpch_pkg::HS_BIT];
          s_d.mgmt = mgmtIn;
          s_d.rsv = ch.reqByte[1];
          s_d.idx = {ch.reqByte[2], ch.reqByte[3]};
          s_d.data = {ch.reqByte[4], ch.reqByte[5], ch.reqByte[6], ch.reqByte[7]};
          s_d.cnt = 8'(EXEC_CYC);
          s_d.busy = 1'b1;
          s_d.st = EXEC;
        end
      end
      EXEC:
      begin
        if (s_q.cnt != 8'h00)
          s_d.cnt = s_q.cnt - 8'h01;
        else
        begin
          s_d.err = 1'b1;
          if (codeBad)
            s_d.res = errWord(cpch_pkg::ECLS_SERVICE, cpch_pkg::ECOD_ILLEGAL);
          else if (isRead)
          begin
            if (intFault)
              s_d.res = errWord(cpch_pkg::ECLS_ACCESS, cpch_pkg::ECOD_HW);
            else
            begin
              s_d.res = memRd;
              s_d.err = 1'b0;
            end
          end
          else if (isWrite)
          begin
            if (!lenOk)
              s_d.res = errWord(cpch_pkg::ECLS_ACCESS, cpch_pkg::ECOD_TYPE);
            else if (intFault)
              s_d.res = errWord(cpch_pkg::ECLS_ACCESS, cpch_pkg::ECOD_HW);
            else
            begin
              memWe = 1'b1;
              s_d.res = s_q.data;
              s_d.err = 1'b0;
            end
          end
          else
            s_d.res = errWord(cpch_pkg::ECLS_SERVICE, cpch_pkg::ECOD_ILLEGAL);
          s_d.st = DONE;
        end
      end
      DONE:
      begin
        s_d.hsOut = s_q.hsSeen;
        s_d.busy = 1'b0;
        s_d.st = IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // registers and parameter store
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      s_q <= '{st: IDLE, default: '0};
    end
    else
      s_q <= s_d;
  end

  // parameter store, written once at the end of a good write service
  always_ff @(posedge clk)
  begin
    if (memWe)
      mem[addrOf(s_q.idx)] <= s_q.data;
  end

  // ---------------------------------------------------------------
  // reply telegram
  // ---------------------------------------------------------------
  // reply: echoes code and index, old handshake, status bit on failure
  always_comb
  begin
    ch.rspByte[0] = {s_q.err & ~s_q.busy, s_q.hsOut, s_q.mgmt[5:0]};
    ch.rspByte[1] = 8'h00;
    ch.rspByte[2] = s_q.idx[15:8];
    ch.rspByte[3] = s_q.idx[7:0];
    ch.rspByte[4] = s_q.res[31:24];
    ch.rspByte[5] = s_q.res[23:16];
    ch.rspByte[6] = s_q.res[15:8];
    ch.rspByte[7] = s_q.res[7:0];
  end
  assign busy = s_q.busy;
endmodule

// ==== src/cpch_pkg.sv ====
// cpch_pkg: constants shared by both ends of the parameter channel
package cpch_pkg;
  // ---------------------------------------------------------------
  // management byte layout
  // ---------------------------------------------------------------
  localparam int SID_LSB = 0;
  localparam int SID_W = 4;
  localparam int LEN_LSB = 4;
  localparam int LEN_W = 2;
  localparam int HS_BIT = 6;
  localparam logic [3:0] SID_READ = 4'h1;
  localparam logic [3:0] SID_WRITE = 4'h2;
  localparam logic [1:0] LEN_FOUR = 2'h3;
  localparam logic [7:0] MGMT_READ = 8'h01;
  localparam logic [7:0] MGMT_WRITE = 8'h32;
  // ---------------------------------------------------------------
  // return codes
  // ---------------------------------------------------------------
  localparam logic [7:0] ECLS_SERVICE = 8'h05;
  localparam logic [7:0] ECOD_ILLEGAL = 8'h05;
  localparam logic [7:0] ECLS_ACCESS = 8'h06;
  localparam logic [7:0] ECOD_TYPE = 8'h08;
  localparam logic [7:0] ECOD_HW = 8'h02;
  localparam logic [7:0] STATUS_BIT = 8'h80;
  localparam int TIMEOUT_CYC = 1000;
  // ---------------------------------------------------------------
  // APB register map of the controller end
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_INDEX = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam logic [7:0] REG_REPLY = 8'h14;
  localparam int CTRL_GO = 0;
  localparam int CTRL_WRITE = 1;
endpackage

// ==== src/cpch_if.sv ====
// cpch_if: the eight-byte cyclic channel between controller and device
`timescale 1ns/1ps
interface cpch_if;
  logic [7:0] reqByte [0:7];
  logic [7:0] rspByte [0:7];
  modport ctrl (output reqByte, input rspByte);
  modport dev (input reqByte, output rspByte);
endinterface

// ==== src/cpch_master.sv ====
// cpch_master: controller end driven by APB registers
`timescale 1ns/1ps
module cpch_master (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // channel
  cpch_if.ctrl             ch
);
  typedef enum logic [1:0] {IDLE, PREP, TOGG, WAIT} cpch_mst_e;
  typedef struct packed {
    cpch_mst_e   st;
    logic        hs;
    logic        wr;
    logic [15:0] idx;
    logic [31:0] wdat;
    logic [7:0]  mgmt;
    logic [31:0] rdat;
    logic [7:0]  rmgmt;
    logic        done;
    logic [31:0] prd;
    logic        rdy;
  } cpch_mst_s;
  cpch_mst_s s_q, s_d;
  logic acc;
  assign acc = psel & penable & s_q.rdy; // access edge at which pready is high

  // ---------------------------------------------------------------
  // next state and register access
  // ---------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    // one wait state: read data is loaded at the same edge at which pready rises
    s_d.rdy = psel & penable & ~s_q.rdy;
    if (acc && pwrite)
    begin
      unique case (paddr)
        cpch_pkg::REG_INDEX: s_d.idx = pwdata[15:0];
        cpch_pkg::REG_WDATA: s_d.wdat = pwdata;
        cpch_pkg::REG_CTRL:
          if (pwdata[cpch_pkg::CTRL_GO] && s_q.st == IDLE)
          begin
            s_d.wr = pwdata[cpch_pkg::CTRL_WRITE];
            s_d.done = 1'b0;
            s_d.st = PREP;
          end
        default: ;
      endcase
    end
    if (psel && penable && !s_q.rdy && !pwrite)
    begin
      unique case (paddr)
        cpch_pkg::REG_STATUS: s_d.prd = {30'h0, s_q.done, s_q.st != IDLE};
        cpch_pkg::REG_RDATA: s_d.prd = s_q.rdat;
        cpch_pkg::REG_REPLY: s_d.prd = {24'h0, s_q.rmgmt};
        cpch_pkg::REG_INDEX: s_d.prd = {16'h0, s_q.idx};
        cpch_pkg::REG_WDATA: s_d.prd = s_q.wdat;
        default: s_d.prd = 32'h0000_0000;
      endcase
    end
    unique case (s_q.st)
      IDLE: ;
      PREP:
      begin
        // index and data first, then mgmt with old handshake
        s_d.mgmt = (s_q.wr ? cpch_pkg::MGMT_WRITE : cpch_pkg::MGMT_READ) | {1'b0, s_q.hs, 6'h00};
        s_d.st = TOGG;
      end
      TOGG:
      begin
        s_d.hs = ~s_q.hs;
        s_d.mgmt[cpch_pkg::HS_BIT] = ~s_q.hs;
        s_d.st = WAIT;
      end
      WAIT:
        if (ch.rspByte[0][cpch_pkg::HS_BIT] == s_q.hs)
        begin
          s_d.rdat = {ch.rspByte[4], ch.rspByte[5], ch.rspByte[6], ch.rspByte[7]};
          s_d.rmgmt = ch.rspByte[0];
          s_d.done = 1'b1;
          s_d.st = IDLE;
        end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      s_q <= '{st: IDLE, default: '0};
    else
      s_q <= s_d;
  end

  // channel request bytes
  always_comb
  begin
    ch.reqByte[0] = s_q.mgmt;
    ch.reqByte[1] = 8'h00;
    ch.reqByte[2] = s_q.idx[15:8];
    ch.reqByte[3] = s_q.idx[7:0];
    ch.reqByte[4] = s_q.wdat[31:24];
    ch.reqByte[5] = s_q.wdat[23:16];
    ch.reqByte[6] = s_q.wdat[15:8];
    ch.reqByte[7] = s_q.wdat[7:0];
  end
  assign prdata = s_q.prd;
  assign pready = s_q.rdy;
  assign pslverr = 1'b0;
endmodule

// ==== tb/cpch_assertions.sv ====
// cpch_assertions: handshake checks on the channel between controller and device
`timescale 1ns/1ps
module cpch_assertions (
  // clock and reset
  input wire logic       clk,
  input wire logic       resetn,
  // channel bytes
  input wire logic [7:0] reqByte [0:7],
  input wire logic [7:0] rspByte [0:7]
);
  logic hsReq;
  logic hsRsp;
  // handshake bits of request and reply
  assign hsReq = reqByte[0][cpch_pkg::HS_BIT];
  assign hsRsp = rspByte[0][cpch_pkg::HS_BIT];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_answer; $changed(hsReq) |-> ##[1:40] (hsRsp == hsReq); endproperty
  a_answer: assert property (p_answer) else $error("reply handshake late");
  property p_keep; $changed(hsReq) |=> $stable(hsRsp) [*3]; endproperty
  a_keep: assert property (p_keep) else $error("reply handshake moved early");
  property p_idle; (hsReq == hsRsp) && $stable(hsReq) |=> $stable(hsRsp); endproperty
  a_idle: assert property (p_idle) else $error("reply moved with no request");
  property p_wait; (hsReq != hsRsp) |=> $stable(hsReq); endproperty
  a_wait: assert property (p_wait) else $error("request toggled while pending");
  property p_prep; $changed(hsReq) |-> $stable(reqByte[0][5:0]) && $stable(reqByte[3]) && $stable(reqByte[4]); endproperty
  a_prep: assert property (p_prep) else $error("bytes changed with toggle");
  property p_code; $changed(hsReq) |-> reqByte[0][5:0] inside {6'h01, 6'h32}; endproperty
  a_code: assert property (p_code) else $error("bad management code");
  property p_index; $changed(hsRsp) |-> rspByte[2] == reqByte[2] && rspByte[3] == reqByte[3]; endproperty
  a_index: assert property (p_index) else $error("reply index differs");
  property p_err; $changed(hsRsp) && rspByte[0][7] |-> rspByte[6] == 8'h00 && rspByte[7] == 8'h00; endproperty
  a_err: assert property (p_err) else $error("additional code not zero");
endmodule

// ==== tb/cyclic_param_channel_handshake_tb.sv ====
// cyclic_param_channel_handshake_tb: both ends joined, plus a device fed by a raw driver
`timescale 1ns/1ps
module cyclic_param_channel_handshake_tb;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        intFault = 1'b0;
  logic        busy;
  logic        busy2;
  logic        hs2 = 1'b0;
  logic [31:0] q;
  int          error_cnt = 0;
  int          compares = 0;
  int          cycles = 0;
  cpch_if u_if ();
  cpch_if u_if2 ();
  cpch_master u_cpch_master (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ch(u_if.ctrl));
  cpch_device u_cpch_device (.clk(clk), .resetn(resetn), .ch(u_if.dev), .intFault(intFault), .busy(busy));
  cpch_device u_cpch_device2 (.clk(clk), .resetn(resetn), .ch(u_if2.dev), .intFault(1'b0), .busy(busy2));
  cpch_assertions u_cpch_assertions (.clk(clk), .resetn(resetn), .reqByte(u_if.reqByte), .rspByte(u_if.rspByte));
  // clock and hang guard
  always #4 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      close_out();
    end
  end
  task automatic close_out();
    $display("mismatches %0d, compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // one apb transfer; read data taken at the edge where pready is high, then one idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // full service through the controller registers, polled to completion
  task automatic svc(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] ctl);
    int n;
    apb(1'b1, cpch_pkg::REG_INDEX, {16'h0000, idx});
    apb(1'b1, cpch_pkg::REG_WDATA, d);
    apb(1'b1, cpch_pkg::REG_CTRL, {30'h0000_0000, ctl});
    for (n = 0; n < 50; n++)
    begin
      apb(1'b0, cpch_pkg::REG_STATUS, 32'h0000_0000);
      if (q[1:0] === 2'b10)
        break;
    end
    chk("status", 32'h0000_0002, {30'h0000_0000, q[1:0]});
    chk("busy slverr", 32'h0000_0000, {30'h0000_0000, busy, pslverr});
  endtask
  // raw service on the second channel, checks the return code bytes
  task automatic raw(input logic [7:0] m, input logic [31:0] e);
    int n;
    hs2 = ~hs2;
    u_if2.reqByte[0] <= {1'b0, hs2, m[5:0]};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (u_if2.rspByte[0][6] !== hs2 && n < 40);
    chk("fail bit", 32'h0000_0001, {31'h0000_0000, u_if2.rspByte[0][7]});
    chk("codes", e, {u_if2.rspByte[4], u_if2.rspByte[5], u_if2.rspByte[6], u_if2.rspByte[7]});
  endtask
  initial
  begin
    for (int i = 0; i < 8; i++)
      u_if2.reqByte[i] <= 8'h00;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    svc(16'h0012, 32'hA5A5_1234, 2'b11);
    chk("ok bit", 32'h0000_0000, {31'h0000_0000, u_if.rspByte[0][7]});
    svc(16'h0034, 32'h0BAD_F00D, 2'b11);
    svc(16'h0012, 32'hFFFF_FFFF, 2'b01);
    apb(1'b0, cpch_pkg::REG_RDATA, 32'h0000_0000);
    chk("read 12", 32'hA5A5_1234, q);
    svc(16'h0034, 32'h0000_0000, 2'b01);
    apb(1'b0, cpch_pkg::REG_RDATA, 32'h0000_0000);
    chk("read 34", 32'h0BAD_F00D, q);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, q);
    intFault <= 1'b1;
    svc(16'h0012, 32'h0000_0000, 2'b01);
    chk("fault", 32'h0602_0000, {u_if.rspByte[4], u_if.rspByte[5], u_if.rspByte[6], u_if.rspByte[7]});
    apb(1'b0, cpch_pkg::REG_REPLY, 32'h0000_0000);
    chk("reply", 32'h0000_00C1, q);
    intFault <= 1'b0;
    // second channel: prepare without toggling, device must stay idle
    u_if2.reqByte[0] <= 8'h32;
    u_if2.reqByte[3] <= 8'h07;
    repeat (12) @(posedge clk);
    chk("idle", 32'h0000_0000, {15'h0000, busy2, u_if2.rspByte[0], u_if2.rspByte[3]});
    raw(8'h05, 32'h0505_0000);
    raw(8'h22, 32'h0608_0000);
    u_if2.reqByte[1] <= 8'h01;
    @(posedge clk);
    raw(8'h01, 32'h0505_0000);
    close_out();
  end
endmodule
